/* File: pkg/synth_loop_regs.svh */
/*
 * Constants of the synthesiser loop controller: rates, divider figures,
 * strobe timing and reset values.
 * Assumes a single 20 MHz system clock; included by bare name.
 */
`ifndef SYNTH_LOOP_REGS_SVH
`define SYNTH_LOOP_REGS_SVH

// clock and oscillator rates in Hz
`define CLK_HZ          20000000
`define OSC_HZ          4800000
`define STROBE_HZ       1200
`define PRESC_MAX_HZ    2500000

// one strobe period is four word slots, counted in oscillator edges
`define SLOT_EDGES      (`OSC_HZ / (`STROBE_HZ * 4))

// reference divide base per ratio_sel_b code, shifted by ratio_sel_a code
`define REF_BASE_GND    11'h0F0
`define REF_BASE_OPEN   11'h0C0
`define REF_BASE_WS1    11'h0A0
`define REF_BASE_WS2    11'h080

// range offset in 256-cycle prescaler periods (3840 and 36608)
`define RANGE_OFF_OPEN  8'h0F
`define RANGE_OFF_GND   8'h8F

// strobe patterns over slots 0..3, bit i taken at the end of slot i
`define PAT_GND         4'h0
`define PAT_OPEN        4'hF
`define PAT_WS1         4'h3
`define PAT_WS2         4'h5

// reset values
`define RST_CHANNEL     16'h0000
`define RST_PERIOD      8'h01

`endif

/* File: pkg/synth_loop_pkg.sv */
/*
 * Types of the synthesiser loop controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package synth_loop_pkg;

  // decoded state of a ratio select pin
  typedef enum logic [1:0] {
    STRAP_GND  = 2'b00,
    STRAP_OPEN = 2'b01,
    STRAP_WS1  = 2'b10,
    STRAP_WS2  = 2'b11
  } strap_t;

  // which half of the count period the 8-bit counter is in
  typedef enum logic {
    PASS_CHAN  = 1'b0,
    PASS_RANGE = 1'b1
  } pass_t;

endpackage

/* File: pkg/phase_cmp_if.sv */
/*
 * Carrier between the divider core and the phase/frequency comparator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface phase_cmp_if;
  logic ref_tick;
  logic vco_tick;
  logic pump_up;
  logic pump_down;
  logic locked;

  modport src (output ref_tick, output vco_tick,
               input pump_up, input pump_down, input locked);
  modport cmp (input ref_tick, input vco_tick,
               output pump_up, output pump_down, output locked);
endinterface

/* File: src/phase_cmp.sv */
/*
 * Phase/frequency comparator: two set/reset flags driven by the divided
 * reference and divided VCO ticks, plus a registered lock level.
 * Assumes one-cycle ticks from the divider core on the same clock.
 */
`timescale 1ns/1ns
module phase_cmp (
  // clock and reset
  input  wire logic CLK,
  input  wire logic ARST_N,
  // divider side
  phase_cmp_if.cmp  pc
);

  logic up_q, up_d;
  logic dn_q, dn_d;
  logic lock_q, lock_d;
  logic both;

  ////////////////////////////////////////////////////////////////////////
  // edge flags; a simultaneous pair clears both, so no pulse appears
  assign both   = (up_q | pc.ref_tick) & (dn_q | pc.vco_tick);
  assign up_d   = (up_q | pc.ref_tick) & ~both;
  assign dn_d   = (dn_q | pc.vco_tick) & ~both;
  assign lock_d = ~(up_d | dn_d);

  // flags and lock register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      up_q   <= up_d;
      dn_q   <= dn_d;
      lock_q <= lock_d;
    end
  end

  assign pc.pump_up   = up_q;
  assign pc.pump_down = dn_q;
  assign pc.locked    = lock_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_pump_exclusive: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(up_q && dn_q)) else $error("pump up and down both active");
  chk_ref_leads: assert property (@(posedge CLK) disable iff (!ARST_N)
    (pc.ref_tick && !pc.vco_tick && !dn_q) |=> up_q) else $error("lead not pumped up");
  chk_coincide_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
    (pc.ref_tick && pc.vco_tick && !up_q && !dn_q) |=> (!up_q && !dn_q))
    else $error("coincident edges produced a pulse");
  chk_lock_release: assert property (@(posedge CLK) disable iff (!ARST_N)
    (up_q || dn_q) |-> !lock_q) else $error("lock held during phase error");

  cov_pump_up:   cover property (@(posedge CLK) disable iff (!ARST_N) $rose(up_q));
  cov_pump_down: cover property (@(posedge CLK) disable iff (!ARST_N) $rose(dn_q));

endmodule

/* File: src/synth_loop_controller.sv */
/*
 * Synthesiser loop controller: reference divider with strap decode,
 * data strobes and word capture, four-modulus programmable divider and
 * open-drain comparator outputs.
 * Assumes a 20 MHz CLK, an oscillator and prescaler output each well below
 * half of it, and external pull-ups on the strap and open-drain pins.
 */
`timescale 1ns/1ns
`include "synth_loop_regs.svh"
module synth_loop_controller (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // oscillator and prescaler
  input  wire logic       OSC_IN,
  input  wire logic       PRESC_IN,
  output logic [1:0]      MOD_CTL,
  // straps and range
  input  wire logic       RATIO_SEL_A,
  input  wire logic       RATIO_SEL_B,
  input  wire logic       RANGE_OPEN,
  // channel word inputs
  input  wire logic       PROG_WORD_BIT0,
  input  wire logic       PROG_WORD_BIT1,
  input  wire logic       PROG_WORD_BIT2,
  input  wire logic       PROG_WORD_BIT3,
  // word strobes
  output logic            WORD_STROBE_ONE_O,
  output logic            WORD_STROBE_ONE_OE,
  input  wire logic       WORD_STROBE_ONE_I,
  output logic            WORD_STROBE_TWO_O,
  output logic            WORD_STROBE_TWO_OE,
  input  wire logic       WORD_STROBE_TWO_I,
  // open-drain comparator outputs
  output logic            PUMP_UP_O,
  output logic            PUMP_UP_OE,
  output logic            PUMP_DOWN_O,
  output logic            PUMP_DOWN_OE,
  output logic            LOCK_O,
  output logic            LOCK_OE
);

  // strap history decode; an unknown pattern keeps the previous state
  function automatic synth_loop_pkg::strap_t decode_strap(
    input logic [3:0] hist, input synth_loop_pkg::strap_t prev);
    case (hist)
      `PAT_GND:  decode_strap = synth_loop_pkg::STRAP_GND;
      `PAT_OPEN: decode_strap = synth_loop_pkg::STRAP_OPEN;
      `PAT_WS1:  decode_strap = synth_loop_pkg::STRAP_WS1;
      `PAT_WS2:  decode_strap = synth_loop_pkg::STRAP_WS2;
      default:   decode_strap = prev;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts once 2 and 3 agree
  localparam int SW = 11;
  logic [SW-1:0] pins, s1_q, s2_q, s3_q, flt_q, flt_d;
  logic          osc_q;
  logic          osc_edge, presc_edge;
  logic          ws1_in, ws2_in, sel_a_in, sel_b_in, range_open;
  logic [3:0]    word_in;

  assign pins = {RANGE_OPEN, PROG_WORD_BIT3, PROG_WORD_BIT2, PROG_WORD_BIT1,
                 PROG_WORD_BIT0, RATIO_SEL_B, RATIO_SEL_A, WORD_STROBE_TWO_I,
                 WORD_STROBE_ONE_I, PRESC_IN, OSC_IN};
  assign flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      flt_q <= '0;
      osc_q <= 1'b0;
    end else begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
      osc_q <= flt_q[0];
    end
  end

  // named views of the filtered pins
  logic presc_prev_q;
  assign osc_edge   = flt_q[0] & ~osc_q;
  assign presc_edge = flt_q[1] & ~presc_prev_q;
  assign ws1_in     = flt_q[2];
  assign ws2_in     = flt_q[3];
  assign sel_a_in   = flt_q[4];
  assign sel_b_in   = flt_q[5];
  assign word_in    = flt_q[9:6];
  assign range_open = flt_q[10];

  ////////////////////////////////////////////////////////////////////////
  // word slots: fixed oscillator edge count, independent of the ratio
  logic [9:0] slot_cnt_q;
  logic [1:0] slot_q;
  logic       slot_end;
  logic       ws1_q, ws2_q;

  assign slot_end = osc_edge && (slot_cnt_q == 10'(`SLOT_EDGES - 1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slot_cnt_q   <= '0;
      slot_q       <= 2'h0;
      ws1_q        <= 1'b1;
      ws2_q        <= 1'b1;
      presc_prev_q <= 1'b0;
    end else begin
      presc_prev_q <= flt_q[1];
      if (slot_end) begin
        slot_cnt_q <= '0;
        slot_q     <= slot_q + 2'h1;
        ws1_q      <= ~slot_q[1] ^ slot_q[0];
        ws2_q      <= slot_q[0];
      end else if (osc_edge) begin
        slot_cnt_q <= slot_cnt_q + 10'h001;
      end
    end
  end

  // strobes are plain totem-pole outputs; grounding one is read back
  assign WORD_STROBE_ONE_O  = ws1_q;
  assign WORD_STROBE_ONE_OE = 1'b1;
  assign WORD_STROBE_TWO_O  = ws2_q;
  assign WORD_STROBE_TWO_OE = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // hold detect, strap history and channel word capture
  logic                   hold_q;
  logic [3:0]             hist_a_q, hist_b_q;
  logic [11:0]            stage_q;
  logic [15:0]            chan_q;
  synth_loop_pkg::strap_t sel_a_q, sel_b_q;
  logic                   commit;

  // only judged in slots where strobe two is driven high
  assign commit = slot_end && (slot_q == 2'h3) && !hold_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_q   <= 1'b0;
      hist_a_q <= '0;
      hist_b_q <= '0;
      stage_q  <= '0;
      chan_q   <= `RST_CHANNEL;
      sel_a_q  <= synth_loop_pkg::STRAP_GND;
      sel_b_q  <= synth_loop_pkg::STRAP_GND;
    end else if (slot_end) begin
      if (ws2_q) begin
        hold_q <= ~ws2_in;
      end
      hist_a_q[slot_q] <= sel_a_in;
      hist_b_q[slot_q] <= sel_b_in;
      if (slot_q != 2'h3) begin
        stage_q[{slot_q, 2'b00} +: 4] <= word_in;
      end
      if (commit) begin
        chan_q  <= {word_in, stage_q};
        sel_a_q <= decode_strap({sel_a_in, hist_a_q[2:0]}, sel_a_q);
        sel_b_q <= decode_strap({sel_b_in, hist_b_q[2:0]}, sel_b_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference divider: base by ratio_sel_b row, doubled per ratio_sel_a step
  logic [10:0] ref_base, ratio_w, ref_cnt_q;
  logic        ref_tick_q, ref_wrap;

  assign ref_base = (sel_b_q == synth_loop_pkg::STRAP_GND)  ? `REF_BASE_GND  :
                    (sel_b_q == synth_loop_pkg::STRAP_OPEN) ? `REF_BASE_OPEN :
                    (sel_b_q == synth_loop_pkg::STRAP_WS1)  ? `REF_BASE_WS1  :
                                                              `REF_BASE_WS2;
  assign ratio_w  = ref_base << sel_a_q;
  assign ref_wrap = osc_edge && (ref_cnt_q >= ratio_w - 11'h001);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= ref_wrap;
      if (ref_wrap) begin
        ref_cnt_q <= '0;
      end else if (osc_edge) begin
        ref_cnt_q <= ref_cnt_q + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programmable divider: the 8-bit counter runs a channel pass, then a
  // range pass; the 4-bit counters add +1 and +16 prescaler cycles
  synth_loop_pkg::pass_t pass_q, pass_d;
  logic [7:0] per_q, per_d, range_off;
  logic [3:0] unit_q, unit_d, six_q, six_d;
  logic [1:0] mc_q;
  logic       vco_tick_q, per_last, cycle_end;

  assign range_off = range_open ? `RANGE_OFF_OPEN : `RANGE_OFF_GND;
  assign per_last  = presc_edge && (per_q == 8'h01);
  assign cycle_end = per_last && (pass_q == synth_loop_pkg::PASS_RANGE);

  // next state of the divide cycle
  always_comb begin
    pass_d = pass_q;
    per_d  = per_q;
    unit_d = unit_q;
    six_d  = six_q;
    if (presc_edge) begin
      per_d  = per_q - 8'h01;
      unit_d = (unit_q != 4'h0) ? unit_q - 4'h1 : 4'h0;
      six_d  = (six_q != 4'h0) ? six_q - 4'h1 : 4'h0;
    end
    if (per_last && pass_q == synth_loop_pkg::PASS_CHAN) begin
      pass_d = synth_loop_pkg::PASS_RANGE;
      per_d  = range_off;
    end
    if (cycle_end) begin
      unit_d = chan_q[3:0];
      six_d  = chan_q[7:4];
      if (chan_q[15:8] != 8'h00) begin
        pass_d = synth_loop_pkg::PASS_CHAN;
        per_d  = chan_q[15:8];
      end else begin
        pass_d = synth_loop_pkg::PASS_RANGE;
        per_d  = range_off;
      end
    end
  end

  // divider registers; modulus lines follow the counter state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pass_q     <= synth_loop_pkg::PASS_RANGE;
      per_q      <= `RST_PERIOD;
      unit_q     <= 4'h0;
      six_q      <= 4'h0;
      mc_q       <= 2'b00;
      vco_tick_q <= 1'b0;
    end else begin
      pass_q     <= pass_d;
      per_q      <= per_d;
      unit_q     <= unit_d;
      six_q      <= six_d;
      mc_q       <= {six_d != 4'h0, unit_d != 4'h0};
      vco_tick_q <= cycle_end;
    end
  end

  assign MOD_CTL = mc_q;

  ////////////////////////////////////////////////////////////////////////
  // comparator and open-drain pins: data low, enable only to pull down
  phase_cmp_if pc_bus ();
  assign pc_bus.ref_tick = ref_tick_q;
  assign pc_bus.vco_tick = vco_tick_q;

  phase_cmp u_cmp (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .pc     (pc_bus.cmp)
  );

  assign PUMP_UP_O    = 1'b0;
  assign PUMP_UP_OE   = pc_bus.pump_up;
  assign PUMP_DOWN_O  = 1'b0;
  assign PUMP_DOWN_OE = pc_bus.pump_down;
  assign LOCK_O       = 1'b0;
  assign LOCK_OE      = pc_bus.locked;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_ratio_frozen: assert property (@(posedge CLK) disable iff (!ARST_N)
    (hold_q && slot_end) |=> ($stable(sel_a_q) && $stable(sel_b_q)))
    else $error("ratio changed while held");
  chk_channel_frozen: assert property (@(posedge CLK) disable iff (!ARST_N)
    (hold_q && slot_end) |=> $stable(chan_q)) else $error("channel changed while held");
  chk_top_word_last: assert property (@(posedge CLK) disable iff (!ARST_N)
    commit |=> (chan_q[15:12] == $past(word_in) && chan_q[3:0] == $past(stage_q[3:0])))
    else $error("word order wrong");
  chk_slot_code: assert property (@(posedge CLK) disable iff (!ARST_N)
    (slot_end && slot_q == 2'h0) |=> (WORD_STROBE_ONE_O && !WORD_STROBE_TWO_O))
    else $error("second slot code wrong");
  // strobes may only move on the cycle after a slot end, never with the ratio
  chk_slot_length: assert property (@(posedge CLK) disable iff (!ARST_N)
    ($changed(ws1_q) || $changed(ws2_q)) |-> $past(slot_end))
    else $error("strobe moved outside a slot end");
  // skip the tick right after a commit: the count may still run on the old ratio
  chk_ref_period: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ref_tick_q && $stable(sel_a_q) && $stable(sel_b_q)
     && sel_a_q == synth_loop_pkg::STRAP_WS1 && sel_b_q == synth_loop_pkg::STRAP_WS2)
    |-> ($past(ref_cnt_q) == 11'h1FF))
    else $error("strobe strap ratio not 512");
  chk_cycle_reload: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cycle_end && chan_q[15:8] == 8'h00) |=> (per_q == range_off && unit_q == chan_q[3:0]))
    else $error("cycle reload wrong");
  chk_mod_unit: assert property (@(posedge CLK) disable iff (!ARST_N)
    MOD_CTL[0] |-> (unit_q != 4'h0)) else $error("modulus line without count");
  chk_od_never_high: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(PUMP_UP_O || PUMP_DOWN_O || LOCK_O)) else $error("open drain drove high");

  cov_hold:     cover property (@(posedge CLK) disable iff (!ARST_N) $rose(hold_q));
  cov_commit:   cover property (@(posedge CLK) disable iff (!ARST_N) commit);
  cov_vco_tick: cover property (@(posedge CLK) disable iff (!ARST_N) vco_tick_q);

endmodule

/* File: verif/loop_partner.sv */
/*
 * Far-side model: four-modulus prescaler, channel rom and strap wiring.
 * Assumes the bench clock and the block's registered strobe outputs.
 */
`timescale 1ns/1ns
module loop_partner (
  // clock
  input  wire logic                   clk,
  // block side
  input  wire logic [1:0]             mod_ctl,
  input  wire logic                   ws1_o,
  input  wire logic                   ws2_o,
  output logic                        presc,
  output logic                        ws1_i,
  output logic                        ws2_i,
  output logic                        sel_a,
  output logic                        sel_b,
  output logic [3:0]                  word,
  // bench side
  input  wire logic                   gnd_two,
  input  wire synth_loop_pkg::strap_t strap_a,
  input  wire synth_loop_pkg::strap_t strap_b,
  input  wire logic [15:0]            chan,
  input  wire logic [7:0]             half
);
  logic [1:0] slot;
  logic [1:0] prev;
  int         acc;
  int         total;
  int         seen;

  // pin levels: a grounded strobe two beats its driver
  assign ws1_i = ws1_o;
  assign ws2_i = gnd_two ? 1'b0 : ws2_o;
  assign slot  = {~ws1_i, ~ws2_i};

  // strap pin level for each wiring choice
  function automatic logic pin(synth_loop_pkg::strap_t s);
    case (s)
      synth_loop_pkg::STRAP_GND:  return 1'b0;
      synth_loop_pkg::STRAP_OPEN: return 1'b1;
      synth_loop_pkg::STRAP_WS1:  return ws1_i;
      default:                    return ws2_i;
    endcase
  endfunction

  // rom answers one clock late; data then stands a whole slot
  always @(posedge clk) begin
    sel_a <= #2 pin(strap_a);
    sel_b <= #2 pin(strap_b);
    word  <= #2 4'(chan >> {slot, 2'b00});
  end

  // modulus sampled once a period, summed over each count period
  initial begin
    presc = 1'b0;
    prev  = 2'b00;
    acc   = 0;
    total = 0;
    seen  = 0;
    forever begin
      repeat (half) @(posedge clk);
      #2 presc = 1'b0;
      repeat (half) @(posedge clk);
      #2;
      if (mod_ctl == 2'b11 && prev == 2'b00) begin
        total = acc;
        seen  = seen + 1;
        acc   = 0;
      end
      acc   = acc + 256 + mod_ctl[0] + 16 * mod_ctl[1];
      prev  = mod_ctl;
      presc = 1'b1;
    end
  end
endmodule

/* File: verif/testbench.sv */
/*
 * Bench of the loop controller: clock, slowed oscillator, far-side model,
 * one task per scenario and the verdict.
 * Assumes the design package and the partner model compiled first.
 */
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got); end end
module testbench;
  // block pins
  logic                   CLK;
  logic                   ARST_N = 1'b0;
  logic                   OSC_IN = 1'b0;
  logic                   RANGE_OPEN = 1'b1;
  logic                   PRESC_IN, RATIO_SEL_A, RATIO_SEL_B;
  logic [1:0]             MOD_CTL;
  logic [3:0]             word;
  logic                   ws1_o, ws1_oe, ws1_i, ws2_o, ws2_oe, ws2_i;
  logic                   pu_o, pu_oe, pd_o, pd_oe, lk_o, lk_oe;
  // far-side settings and bookkeeping
  logic                   gnd_two = 1'b0;
  synth_loop_pkg::strap_t strap_a = synth_loop_pkg::STRAP_WS1;
  synth_loop_pkg::strap_t strap_b = synth_loop_pkg::STRAP_WS2;
  logic [15:0]            chan = 16'hFFFF;
  logic [7:0]             half = 8'h04;
  int                     cyc = 0, osc_n = 0, err_total = 0, checked = 0;

  ////////////////////////////////////////////////////////////////////////
  synth_loop_controller dut_u (
    .CLK(CLK), .ARST_N(ARST_N), .OSC_IN(OSC_IN), .PRESC_IN(PRESC_IN),
    .MOD_CTL(MOD_CTL), .RATIO_SEL_A(RATIO_SEL_A), .RATIO_SEL_B(RATIO_SEL_B),
    .RANGE_OPEN(RANGE_OPEN), .PROG_WORD_BIT0(word[0]), .PROG_WORD_BIT1(word[1]),
    .PROG_WORD_BIT2(word[2]), .PROG_WORD_BIT3(word[3]),
    .WORD_STROBE_ONE_O(ws1_o), .WORD_STROBE_ONE_OE(ws1_oe), .WORD_STROBE_ONE_I(ws1_i),
    .WORD_STROBE_TWO_O(ws2_o), .WORD_STROBE_TWO_OE(ws2_oe), .WORD_STROBE_TWO_I(ws2_i),
    .PUMP_UP_O(pu_o), .PUMP_UP_OE(pu_oe), .PUMP_DOWN_O(pd_o), .PUMP_DOWN_OE(pd_oe),
    .LOCK_O(lk_o), .LOCK_OE(lk_oe)
  );
  loop_partner partner_u (
    .clk(CLK), .mod_ctl(MOD_CTL), .ws1_o(ws1_o), .ws2_o(ws2_o), .presc(PRESC_IN),
    .ws1_i(ws1_i), .ws2_i(ws2_i), .sel_a(RATIO_SEL_A), .sel_b(RATIO_SEL_B),
    .word(word), .gnd_two(gnd_two), .strap_a(strap_a), .strap_b(strap_b),
    .chan(chan), .half(half)
  );

  ////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // oscillator slowed to 6 clocks: the input filter wants 3 clocks a phase
  always @(posedge CLK) begin
    osc_n <= (osc_n == 2) ? 0 : osc_n + 1;
    if (osc_n == 2) OSC_IN <= #2 ~OSC_IN;
  end
  // hang guard; the tests need at most about 76000 cycles
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      err_total++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // next change of the strobe code, bounded
  task automatic wait_code(inout logic [1:0] c, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #3;
      n++;
    end while ({ws1_o, ws2_o} === c && n < 7000);
    c = {ws1_o, ws2_o};
  endtask
  // next drop of the down flag, bounded
  task automatic wait_drop(output int n);
    logic p;
    n = 0;
    do begin
      p = pd_oe;
      @(posedge CLK);
      #3;
      n++;
    end while (!(p === 1'b1 && pd_oe === 1'b0) && n < 20000);
  endtask
  // strobes show slot one and nothing pulls low under reset
  task automatic test_reset();
    #3;
    `CHECK("strobes", 2'b11, {ws1_o, ws2_o})
    `CHECK("strobe drive", 2'b11, {ws1_oe, ws2_oe})
    `CHECK("modulus", 2'b00, MOD_CTL)
    `CHECK("comparator", 3'b000, {pu_oe, pd_oe, lk_oe})
    $display("test reset done");
  endtask
  // with a fast loop the down flag drops once per reference period
  task automatic test_ref(string nm, int ratio);
    int n;
    wait_drop(n);
    wait_drop(n);
    `CHECK(nm, ratio * 6, n)
    $display("test %s done", nm);
  endtask
  // codes 11, 10, 01, 00, each for 1000 oscillator periods
  task automatic test_strobes();
    logic [1:0] c;
    logic [1:0] e;
    int n;
    c = {ws1_o, ws2_o};
    wait_code(c, n);
    repeat (3) begin
      e = ~(~c + 2'b01);
      wait_code(c, n);
      `CHECK("slot code", e, c)
      `CHECK("slot cycles", 6000, n)
    end
    $display("test strobes done");
  endtask
  // total division of a count period, summed by the prescaler model
  task automatic test_divider(logic rng, int ex);
    int s;
    int n = 0;
    @(posedge CLK);
    RANGE_OPEN <= #2 rng;
    s = partner_u.seen;
    while (partner_u.seen < s + 3 && n < 20000) begin
      @(posedge CLK);
      n++;
    end
    `CHECK("division", ex, partner_u.total)
    $display("test divider done");
  endtask
  // slow loop pumps up, fast loop pumps down; lock only while both idle
  task automatic test_pump(string nm, logic [7:0] h, logic up);
    int u = 0;
    int d = 0;
    int bad = 0;
    @(posedge CLK);
    half <= #2 h;
    repeat (2000) @(posedge CLK);
    repeat (8000) begin
      @(posedge CLK);
      #3;
      u = u + pu_oe;
      d = d + pd_oe;
      if (lk_oe !== !(pu_oe | pd_oe) || {pu_o, pd_o, lk_o} !== 3'b000) bad++;
    end
    `CHECK(nm, up, u > d)
    `CHECK("lock and drive", 0, bad)
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (19) @(posedge CLK);
    test_reset();
    @(posedge CLK);
    ARST_N <= #2 1'b1;
    test_ref("ref 240", 240);
    test_strobes();
    // commit done: ground strobe two, then move straps and channel
    @(posedge CLK);
    gnd_two <= #2 1'b1;
    strap_a <= #2 synth_loop_pkg::STRAP_OPEN;
    strap_b <= #2 synth_loop_pkg::STRAP_OPEN;
    chan    <= #2 16'h0123;
    test_ref("ref 512", 512);
    test_divider(1'b0, 16'hFFFF + 36608);
    test_divider(1'b1, 16'hFFFF + 3840);
    test_pump("pump up", 8'h0A, 1'b1);
    test_pump("pump down", 8'h04, 1'b0);
    // one commit slot has passed under hold by now
    test_ref("ref held", 512);
    test_divider(1'b1, 16'hFFFF + 3840);
    conclude();
  end
endmodule
